// ==== logic/spicf_core.sv ====
`timescale 1ns/1ps
module spicf_core (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Configuration.
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic clock_idle_polarity,
  input wire logic clock_sample_phase,
  input wire logic frame_size_sixteen,
  input wire logic lsb_first_order,
  input wire logic frame_sync_mode,
  input wire logic [spicf_pkg::SPICF_BAUD_W-1:0] baud_prescaler,
  input wire logic soft_select_enable,
  input wire logic soft_select_level,
  input wire logic select_output_drive,
  input wire logic bidir_mode,
  input wire logic bidir_transmit,
  // Data buffers.
  input wire logic [spicf_pkg::SPICF_WORD_W-1:0] tx_data,
  input wire logic tx_write,
  output logic [spicf_pkg::SPICF_WORD_W-1:0] rx_data,
  input wire logic rx_read,
  // Status.
  output logic tx_buffer_empty_flag,
  output logic rx_buffer_full_flag,
  output logic config_fault_flag,
  input wire logic config_fault_clear,
  output logic master_active,
  output logic busy,
  // Serial clock pin; the input side is the slave link clock.
  input wire logic sck_link_clk,
  output logic sck_o,
  output logic sck_oe,
  // Data pins.
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  // Select pin.
  input wire logic slave_select_line_i,
  output logic slave_select_line_o,
  output logic slave_select_line_oe
);
  import spicf_pkg::*;

  // --------------------------------------------------------------
  // Effective format.
  // --------------------------------------------------------------
  logic cpol_e;
  logic cpha_e;
  logic lsb_e;
  logic [SPICF_IDX_W-1:0] nbits;

  assign cpol_e = frame_sync_mode ? 1'b0 : clock_idle_polarity; // see [RULE4]
  assign cpha_e = frame_sync_mode ? 1'b0 : clock_sample_phase; // see [RULE4]
  assign lsb_e = lsb_first_order & ~frame_sync_mode; // see [RULE7]
  assign nbits = spicf_frame_bits(frame_size_sixteen); // see [RULE5]

  // --------------------------------------------------------------
  // Pin synchronisers.
  // --------------------------------------------------------------
  logic sel_pin_s;
  logic mosi_s;
  logic miso_s;
  logic start_s;
  logic done_s;
  logic sel_link_n;
  logic start_tgl;
  logic done_tgl;

  // The select bit clears high, its idle level, so no false select follows reset.
  spicf_sync #(.W(5), .RST_VAL(5'h10)) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({slave_select_line_i, mosi_i, miso_i, start_tgl, done_tgl}),
    .q({sel_pin_s, mosi_s, miso_s, start_s, done_s})
  );

  logic start_d_ff;
  logic done_d_ff;
  logic slv_start_evt;
  logic slv_done_evt;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      start_d_ff <= 1'b0;
      done_d_ff <= 1'b0;
    end else begin
      start_d_ff <= start_s;
      done_d_ff <= done_s;
    end
  end

  assign slv_start_evt = start_s ^ start_d_ff;
  assign slv_done_evt = done_s ^ done_d_ff;

  // --------------------------------------------------------------
  // Select handling and configuration fault.
  // --------------------------------------------------------------
  logic fault_ff;
  logic sel_level;
  logic sel_is_input;
  logic fault_set;

  assign sel_level = soft_select_enable ? soft_select_level : sel_pin_s; // see [RULE8] [RULE10] [RULE11]
  assign sel_is_input = soft_select_enable | ~select_output_drive; // see [RULE14]
  assign fault_set = master_select & ~fault_ff & sel_is_input & ~sel_level; // see [RULE12]
  assign master_active = master_select & ~fault_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fault_ff <= 1'b0;
    end else if (fault_set) begin
      fault_ff <= 1'b1; // see [RULE12]
    end else if (config_fault_clear) begin
      fault_ff <= 1'b0; // see [RULE22]
    end
  end

  assign config_fault_flag = fault_ff;

  // --------------------------------------------------------------
  // Transmit buffer and its empty flag.
  // --------------------------------------------------------------
  logic [SPICF_WORD_W-1:0] tx_buf_ff;
  logic tx_full_ff;
  logic tx_empty_ff;
  logic mst_load;
  logic slv_load;
  logic mst_first_bit;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_buf_ff <= SPICF_WORD_RST;
      tx_full_ff <= 1'b0;
    end else if (tx_write) begin
      tx_buf_ff <= tx_data; // see [RULE17]
      tx_full_ff <= 1'b1;
    end else if (mst_load | slv_load) begin
      tx_full_ff <= 1'b0; // see [RULE19]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_empty_ff <= 1'b1;
    end else if ((mst_first_bit | (~master_active & slv_start_evt)) & ~tx_full_ff & ~tx_write) begin
      tx_empty_ff <= 1'b1; // see [RULE19]
    end else if (tx_write) begin
      tx_empty_ff <= 1'b0;
    end
  end

  assign tx_buffer_empty_flag = tx_empty_ff;

  // --------------------------------------------------------------
  // Master engine: divider, edges, shifting.
  // --------------------------------------------------------------
  spicf_mst_state_t mst_state_ff;
  logic [SPICF_DIV_W-1:0] div_ff;
  logic [SPICF_EDGE_W-1:0] edge_ff;
  logic [SPICF_WORD_W-1:0] mst_word_ff;
  logic [SPICF_WORD_W-1:0] mst_rx_ff;
  logic [SPICF_WORD_W-1:0] nxt_mst_rx;
  logic sck_ff;
  logic mosi_ff;
  logic tick;
  logic samp_edge;
  logic last_edge;
  logic mst_done;
  logic mst_go;
  logic mst_din;
  logic [SPICF_IDX_W-1:0] bit_idx;
  logic [SPICF_IDX_W-1:0] out_idx;

  assign tick = (div_ff == SPICF_DIV_W'((2 << baud_prescaler) - 1));
  assign bit_idx = SPICF_IDX_W'(edge_ff >> 1);
  assign samp_edge = (edge_ff[0] == cpha_e); // see [RULE3]
  assign out_idx = cpha_e ? bit_idx : bit_idx + 5'h01;
  assign last_edge = (edge_ff == SPICF_EDGE_W'({nbits, 1'b0} - 6'h01));
  assign mst_din = bidir_mode ? mosi_s : miso_s; // see [RULE15] [RULE16]
  assign mst_go = master_active & spi_enable & tx_full_ff & ~tx_write;
  assign mst_load = (mst_state_ff == SPICF_M_IDLE) ? mst_go : (tick & last_edge & mst_go);
  assign mst_done = (mst_state_ff == SPICF_M_RUN) & tick & last_edge;
  assign mst_first_bit = (mst_state_ff == SPICF_M_RUN) & tick & (edge_ff == SPICF_FIRST_BIT_EDGE);

  always_comb begin
    nxt_mst_rx = mst_rx_ff;
    if (samp_edge) begin
      nxt_mst_rx[spicf_bit_pos(bit_idx, lsb_e, frame_size_sixteen)] = mst_din;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mst_state_ff <= SPICF_M_IDLE;
      div_ff <= '0;
      edge_ff <= '0;
      sck_ff <= 1'b0;
      mosi_ff <= 1'b0;
      mst_word_ff <= SPICF_WORD_RST;
      mst_rx_ff <= SPICF_WORD_RST;
    end else begin
      case (mst_state_ff)
        SPICF_M_IDLE: begin
          sck_ff <= cpol_e; // see [RULE2]
          div_ff <= '0;
          edge_ff <= '0;
          if (mst_load) begin
            mst_state_ff <= SPICF_M_RUN; // see [RULE18]
            mst_word_ff <= tx_buf_ff;
            if (!cpha_e) begin
              mosi_ff <= tx_buf_ff[spicf_bit_pos('0, lsb_e, frame_size_sixteen)];
            end
          end
        end
        SPICF_M_RUN: begin
          if (!master_active || !spi_enable) begin
            mst_state_ff <= SPICF_M_IDLE;
          end else if (tick) begin
            div_ff <= '0;
            sck_ff <= ~sck_ff; // see [RULE1]
            mst_rx_ff <= nxt_mst_rx; // see [RULE3]
            if (last_edge) begin
              edge_ff <= '0;
              if (mst_load) begin
                mst_word_ff <= tx_buf_ff;
                if (!cpha_e) begin
                  mosi_ff <= tx_buf_ff[spicf_bit_pos('0, lsb_e, frame_size_sixteen)];
                end
              end else begin
                mst_state_ff <= SPICF_M_IDLE;
              end
            end else begin
              edge_ff <= edge_ff + 6'h01;
              if (!samp_edge) begin
                mosi_ff <= mst_word_ff[spicf_bit_pos(out_idx, lsb_e, frame_size_sixteen)]; // see [RULE6]
              end
            end
          end else begin
            div_ff <= div_ff + 9'h001;
          end
        end
        default: begin
          mst_state_ff <= SPICF_M_IDLE;
        end
      endcase
    end
  end

  // --------------------------------------------------------------
  // Slave engine on the pin clock.
  // --------------------------------------------------------------
  logic [SPICF_WORD_W-1:0] slv_word_ff;
  logic [SPICF_WORD_W-1:0] slv_rx_word;
  logic slv_dout;
  logic slv_din;
  logic sample_clk;
  logic sel_raw;
  logic slv_sel_s;

  // Polarity and phase are steady during frames, so a plain XOR forms the sampling clock.
  assign sample_clk = sck_link_clk ^ (cpol_e ^ cpha_e); // see [RULE3]
  assign sel_raw = soft_select_enable ? soft_select_level : slave_select_line_i; // see [RULE8]
  assign sel_link_n = master_active | ~spi_enable | sel_raw; // see [RULE9]
  assign slv_din = bidir_mode ? miso_i : mosi_i; // see [RULE15] [RULE16]

  spicf_link_slave u_link (
    .sample_clk(sample_clk),
    .rst(rst),
    .sel_n(sel_link_n),
    .frame_long(frame_size_sixteen),
    .lsb_first(lsb_e),
    .tx_word(slv_word_ff),
    .din(slv_din),
    .dout(slv_dout),
    .rx_word(slv_rx_word),
    .start_tgl(start_tgl),
    .done_tgl(done_tgl)
  );

  assign slv_sel_s = ~master_active & spi_enable & ~sel_level;
  assign slv_load = ~master_active & tx_full_ff & ~tx_write & (~slv_sel_s | slv_done_evt);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      slv_word_ff <= SPICF_WORD_RST;
    end else if (slv_load) begin
      slv_word_ff <= tx_buf_ff; // see [RULE19]
    end
  end

  // --------------------------------------------------------------
  // Receive buffer and its full flag.
  // --------------------------------------------------------------
  logic [SPICF_WORD_W-1:0] rx_buf_ff;
  logic rx_full_ff;
  logic rx_evt;

  assign rx_evt = mst_done | (~master_active & slv_done_evt);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_buf_ff <= SPICF_WORD_RST;
    end else if (rx_evt) begin
      rx_buf_ff <= mst_done ? nxt_mst_rx : slv_rx_word; // see [RULE17] [RULE20]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_full_ff <= 1'b0;
    end else if (rx_evt) begin
      rx_full_ff <= 1'b1; // see [RULE20]
    end else if (rx_read) begin
      rx_full_ff <= 1'b0;
    end
  end

  assign rx_data = rx_buf_ff;
  assign rx_buffer_full_flag = rx_full_ff;
  assign busy = (mst_state_ff == SPICF_M_RUN) | slv_sel_s;

  // --------------------------------------------------------------
  // Pin drivers.
  // --------------------------------------------------------------
  logic sel_drive;

  assign sel_drive = master_active & ~soft_select_enable & select_output_drive; // see [RULE13]
  assign slave_select_line_oe = sel_drive;
  assign slave_select_line_o = ~spi_enable; // see [RULE13] [RULE23]
  assign sck_o = sck_ff;
  assign sck_oe = master_active; // see [RULE1]
  assign mosi_o = mosi_ff;
  assign mosi_oe = master_active & spi_enable & (~bidir_mode | bidir_transmit); // see [RULE15] [RULE16]
  assign miso_o = slv_dout;
  assign miso_oe = ~sel_link_n & (~bidir_mode | bidir_transmit); // see [RULE9] [RULE16]
endmodule : spicf_core

// ==== logic/spicf_pkg.sv ====
// Functional notes
// [RULE1] Master drives the serial clock pin; slave takes it as input from the far master.
// [RULE2] Serial clock rests at the idle polarity level whenever no frame is running.
// [RULE3] Clock phase picks first or second edge as sampling edge for each bit.
// [RULE4] Frame sync mode ignores clock polarity and phase settings entirely.
// [RULE5] Frames are sixteen bits with frame size bit set, else eight bits.
// [RULE6] Least significant bit goes first when lsb order is 1, else most significant.
// [RULE7] Frame sync mode always sends the most significant bit first.
// [RULE8] Slave select level comes from pin, or from the soft level bit when enabled.
// [RULE9] Slave moves data only while its effective select level is low.
// [RULE10] Soft select mode: level low when soft bit is 0, high when 1.
// [RULE11] Slave with hardware select treats the select pin as chip select.
// [RULE12] Master with select input or soft select falls to slave on low, flags fault.
// [RULE13] Master with hardware select and drive set drives select low once enabled.
// [RULE14] Master with soft select level 1 stays master and ignores drive control.
// [RULE15] Two lines: master sends on mosi, receives on miso; slave the reverse.
// [RULE16] Single line: master uses mosi both ways, slave uses miso both ways.
// [RULE17] Separate sixteen bit transmit and receive buffers hold frames independently.
// [RULE18] Master starts a frame when software writes the transmit buffer while enabled.
// [RULE19] Frame moves to shifter; empty flag sets after its first bit is sent.
// [RULE20] After last sample the frame goes to receive buffer and full flag sets.
// [RULE21] Software keeps phase, polarity, role, prescaler and order steady during frames.
// [RULE22] Fault flag stays set after the fall to slave until software clears it.
// [RULE23] Driven select output returns high when the interface is disabled.
package spicf_pkg;
  localparam int SPICF_WORD_W = 16;
  localparam int SPICF_IDX_W = 5;
  localparam int SPICF_BAUD_W = 3;
  localparam int SPICF_DIV_W = 9;
  localparam int SPICF_EDGE_W = 6;
  localparam logic [SPICF_IDX_W-1:0] SPICF_SHORT_BITS = 5'h08;
  localparam logic [SPICF_IDX_W-1:0] SPICF_LONG_BITS = 5'h10;
  localparam logic [SPICF_WORD_W-1:0] SPICF_WORD_RST = 16'h0000;
  localparam logic [SPICF_EDGE_W-1:0] SPICF_FIRST_BIT_EDGE = 6'h01;

  typedef enum logic [1:0] {
    SPICF_M_IDLE = 2'b01,
    SPICF_M_RUN = 2'b10
  } spicf_mst_state_t;

  // Number of bits in one frame.
  function automatic logic [SPICF_IDX_W-1:0] spicf_frame_bits(input logic long_frame);
    spicf_frame_bits = long_frame ? SPICF_LONG_BITS : SPICF_SHORT_BITS; // see [RULE5]
  endfunction : spicf_frame_bits

  // Word bit that travels in serial slot idx.
  function automatic logic [3:0] spicf_bit_pos(input logic [SPICF_IDX_W-1:0] idx, input logic lsb,
                                               input logic long_frame);
    logic [SPICF_IDX_W-1:0] last;
    last = spicf_frame_bits(long_frame) - 5'h01;
    spicf_bit_pos = lsb ? idx[3:0] : 4'(last - idx); // see [RULE6]
  endfunction : spicf_bit_pos
endpackage : spicf_pkg

// ==== logic/spicf_sync.sv ====
`timescale 1ns/1ps
module spicf_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Asynchronous levels in, synchronised levels out.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= RST_VAL;
      q_ff <= RST_VAL;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : spicf_sync

// ==== logic/spicf_link_slave.sv ====
`timescale 1ns/1ps
module spicf_link_slave (
  // Sampling clock built from the pin and reset.
  input wire logic sample_clk,
  input wire logic rst,
  input wire logic sel_n,
  // Frame format, steady while selected.
  input wire logic frame_long,
  input wire logic lsb_first,
  // Data.
  input wire logic [spicf_pkg::SPICF_WORD_W-1:0] tx_word,
  input wire logic din,
  output logic dout,
  output logic [spicf_pkg::SPICF_WORD_W-1:0] rx_word,
  // Events toward the system clock.
  output logic start_tgl,
  output logic done_tgl
);
  import spicf_pkg::*;

  logic [SPICF_IDX_W-1:0] cnt_ff;
  logic [SPICF_WORD_W-1:0] sh_ff;
  logic [SPICF_WORD_W-1:0] nxt_sh;
  logic [SPICF_WORD_W-1:0] rx_word_ff;
  logic start_ff;
  logic done_ff;
  logic last_bit;

  assign last_bit = (cnt_ff == spicf_frame_bits(frame_long) - 5'h01);

  always_comb begin
    nxt_sh = sh_ff;
    nxt_sh[spicf_bit_pos(cnt_ff, lsb_first, frame_long)] = din;
  end

  // --------------------------------------------------------------
  // Bit slot counter, held clear while deselected.
  // --------------------------------------------------------------
  always_ff @(posedge sample_clk or posedge sel_n) begin
    if (sel_n) begin
      cnt_ff <= '0; // see [RULE9]
      sh_ff <= SPICF_WORD_RST;
    end else begin
      cnt_ff <= last_bit ? '0 : cnt_ff + 5'h01;
      sh_ff <= nxt_sh; // see [RULE3]
    end
  end

  // --------------------------------------------------------------
  // Received word and event toggles survive deselection.
  // --------------------------------------------------------------
  always_ff @(posedge sample_clk or posedge rst) begin
    if (rst) begin
      rx_word_ff <= SPICF_WORD_RST;
      start_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      // Only a selected frame start counts; the master's own clock also reaches here.
      if (!sel_n && cnt_ff == '0) begin
        start_ff <= ~start_ff; // see [RULE19]
      end
      if (last_bit) begin
        rx_word_ff <= nxt_sh; // see [RULE20]
        done_ff <= ~done_ff;
      end
    end
  end

  // The next bit is presented right after each sampling edge.
  assign dout = tx_word[spicf_bit_pos(cnt_ff, lsb_first, frame_long)];
  assign rx_word = rx_word_ff;
  assign start_tgl = start_ff;
  assign done_tgl = done_ff;
endmodule : spicf_link_slave

// ==== tb/spicf_props.sv ====
`timescale 1ns/1ps
module spicf_props (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Controls.
  input wire logic spi_enable,
  input wire logic master_select,
  input wire logic clock_idle_polarity,
  input wire logic frame_sync_mode,
  input wire logic soft_select_enable,
  input wire logic soft_select_level,
  input wire logic select_output_drive,
  input wire logic bidir_mode,
  input wire logic tx_write,
  input wire logic rx_read,
  input wire logic config_fault_clear,
  // Status.
  input wire logic tx_buffer_empty_flag,
  input wire logic rx_buffer_full_flag,
  input wire logic config_fault_flag,
  input wire logic master_active,
  input wire logic busy,
  // Pins.
  input wire logic sck_o,
  input wire logic sck_oe,
  input wire logic mosi_oe,
  input wire logic miso_oe,
  input wire logic slave_select_line_o,
  input wire logic slave_select_line_oe
);
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic idle_lvl;
  assign idle_lvl = clock_idle_polarity & !frame_sync_mode;
  a_sck_drive: assert property (sck_oe == (master_select && !config_fault_flag))
    else $error("sck drive enable wrong");
  a_sck_idle: assert property (!busy && !$past(busy) && $past(sck_oe) && sck_oe && $stable(clock_idle_polarity)
    && $stable(frame_sync_mode) |-> sck_o == idle_lvl)
    else $error("sck not at idle level");
  a_frame_end_idle: assert property ($rose(rx_buffer_full_flag) && master_active |-> sck_o == idle_lvl)
    else $error("frame ended off idle level");
  a_sel_out_low: assert property (master_active && spi_enable && !soft_select_enable && select_output_drive
    |-> slave_select_line_oe && !slave_select_line_o)
    else $error("select output not low");
  a_sel_off_high: assert property (slave_select_line_oe && !spi_enable |-> slave_select_line_o)
    else $error("select output not high when disabled");
  a_fault_sets: assert property (spi_enable && master_active && soft_select_enable && !soft_select_level
    |-> ##[1:4] config_fault_flag)
    else $error("fault flag not set");
  a_fault_role: assert property (config_fault_flag && $past(config_fault_flag) |-> !master_active)
    else $error("master kept after fault");
  a_fault_holds: assert property (config_fault_flag && !config_fault_clear |=> config_fault_flag)
    else $error("fault flag lost");
  a_soft_stays: assert property ((master_select && soft_select_enable && soft_select_level
    && !config_fault_flag) [*4] |=> !config_fault_flag)
    else $error("fault with soft level high");
  a_tx_empty_low: assert property (tx_write |=> !tx_buffer_empty_flag)
    else $error("empty flag high after write");
  a_rx_full_clear: assert property (rx_read && !busy |=> !rx_buffer_full_flag)
    else $error("full flag not cleared by read");
  a_data_roles: assert property (master_active && spi_enable && !bidir_mode |-> mosi_oe && !miso_oe)
    else $error("master data pin roles wrong");
  c_master_frame: cover property ($rose(rx_buffer_full_flag) && master_active);
  c_slave_drive: cover property (!master_active && miso_oe);
  c_fault: cover property ($rose(config_fault_flag));
endmodule : spicf_props

bind spicf_core spicf_props u_props (.*);

// ==== tb/spicf_peer.sv ====
`timescale 1ns/1ps
module spicf_peer (
  // Far master pins.
  output logic sck,
  output logic mosi,
  output logic sel_n,
  input wire logic miso
);
  // ----------------------------------------
  // Far master model
  // ----------------------------------------
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    sel_n = 1'b1;
  end
  // One 8-bit frame, clock mode 0, MSB first; the clock stands still outside it.
  task automatic xfer(input logic [15:0] w, input logic use_sel, output logic [15:0] r);
    r = 16'h0000;
    sel_n = !use_sel;
    #42.7;
    for (int i = 7; i >= 0; i--) begin
      mosi = w[i];
      #15 r = {r[14:0], miso};
      sck = 1'b1;
      #15 sck = 1'b0;
    end
    mosi = !mosi;
    #20 sel_n = 1'b1;
  endtask : xfer
endmodule : spicf_peer

// ==== tb/tb.sv ====
`timescale 1ns/1ps
module tb;
  import spicf_pkg::*;
  // ----------------------------------------
  // Signals, pins and helpers
  // ----------------------------------------
  logic sys_clk = 1'b0, rst = 1'b1, spi_enable = 1'b0, master_select = 1'b1, pull = 1'b0;
  logic clock_idle_polarity = 1'b0, clock_sample_phase = 1'b0, frame_size_sixteen = 1'b0;
  logic lsb_first_order = 1'b0, frame_sync_mode = 1'b0, soft_select_enable = 1'b0;
  logic soft_select_level = 1'b1, select_output_drive = 1'b1, bidir_mode = 1'b0, bidir_transmit = 1'b0;
  logic tx_write = 1'b0, rx_read = 1'b0, config_fault_clear = 1'b0;
  logic [SPICF_WORD_W-1:0] tx_data = 16'h0000;
  logic [SPICF_BAUD_W-1:0] baud_prescaler = 3'h1;
  logic [SPICF_WORD_W-1:0] rx_data;
  logic tx_buffer_empty_flag, rx_buffer_full_flag, config_fault_flag, master_active, busy;
  logic sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe, slave_select_line_o, slave_select_line_oe;
  logic peer_sck, peer_mosi, peer_sel_n, ecpol, ecpha, elsb;
  wire logic sck_link_clk = sck_oe ? sck_o : peer_sck;
  wire logic mosi_i = mosi_oe ? mosi_o : peer_mosi;
  wire logic miso_i = miso_oe ? miso_o : mosi_o;
  wire logic slave_select_line_i = slave_select_line_oe ? slave_select_line_o : peer_sel_n & !pull;
  int n_fail = 0, tests_run = 0, cyc = 0, ncap = 0, n;
  logic [15:0] cap, ew, m, pr;
  logic [20:0] rows [7] = '{{5'b00000, 16'h00b4}, {5'b01000, 16'h00b4}, {5'b10110, 16'hc3a5},
    {5'b11100, 16'h1e2d}, {5'b00010, 16'h0069}, {5'b01111, 16'h0096}, {5'b11001, 16'h8001}};

  spicf_core DUT (.*);
  spicf_peer u_peer (.sck(peer_sck), .mosi(peer_mosi), .sel_n(peer_sel_n), .miso(miso_i));

  initial begin
    forever #2.5 sys_clk = !sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  // Records the master's data line at each sampling edge.
  always @(sck_o) begin
    if (sck_oe && sck_o == (ecpol ^ !ecpha)) begin
      cap = {cap[14:0], mosi_o};
      ncap++;
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask : tick
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic pulse_write(input logic [15:0] d);
    tx_data = d;
    tx_write = 1'b1;
    tick(1);
    tx_write = 1'b0;
  endtask : pulse_write
  task automatic pulse_read();
    rx_read = 1'b1;
    tick(1);
    rx_read = 1'b0;
    tick(1);
  endtask : pulse_read
  task automatic clear_fault();
    config_fault_clear = 1'b1;
    tick(1);
    config_fault_clear = 1'b0;
    tick(1);
  endtask : clear_fault
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    tick(8);
    rst = 1'b0;
    chk("reset tx empty", 16'h1, tx_buffer_empty_flag);
    chk("reset rx full", 16'h0, rx_buffer_full_flag);
    chk("reset fault", 16'h0, config_fault_flag);
    spi_enable = 1'b1;
    tick(2);
    chk("select out", 16'h0, slave_select_line_o);
    foreach (rows[i]) begin
      {frame_size_sixteen, lsb_first_order, clock_idle_polarity, clock_sample_phase, frame_sync_mode,
        tx_data} = rows[i];
      ecpol = clock_idle_polarity & !frame_sync_mode;
      ecpha = clock_sample_phase & !frame_sync_mode;
      elsb = lsb_first_order & !frame_sync_mode;
      n = frame_size_sixteen ? 16 : 8;
      m = frame_size_sixteen ? 16'hffff : 16'h00ff;
      ew = 16'h0000;
      for (int b = 0; b < n; b++) ew[b] = elsb ? tx_data[n-1-b] : tx_data[b];
      tick(3);
      // The idle level may move with the new row, so capture starts afterwards.
      cap = 16'h0000;
      ncap = 0;
      chk("idle sck", 16'(ecpol), sck_o);
      pulse_write(tx_data);
      chk("tx empty after write", 16'h0, tx_buffer_empty_flag);
      tick(1);
      chk("busy start", 16'h1, busy);
      for (int k = 0; k < 400 && busy !== 1'b0; k++) tick(1);
      chk("busy end", 16'h0, busy);
      chk("tx empty after frame", 16'h1, tx_buffer_empty_flag);
      chk("rx full", 16'h1, rx_buffer_full_flag);
      chk("rx data", tx_data & m, rx_data & m);
      chk("wire order", ew, cap);
      chk("bit count", 16'(n), 16'(ncap));
      chk("idle after", 16'(ecpol), sck_o);
      pulse_read();
      chk("rx full read", 16'h0, rx_buffer_full_flag);
      $display("row %0d done", i);
    end
    {frame_size_sixteen, lsb_first_order, clock_idle_polarity, clock_sample_phase, frame_sync_mode} = 5'h00;
    bidir_mode = 1'b1;
    bidir_transmit = 1'b1;
    pulse_write(16'h005a);
    tick(150);
    chk("bidir rx", 16'h005a, rx_data & 16'h00ff);
    chk("bidir oe", 16'h1, mosi_oe);
    pulse_read();
    bidir_mode = 1'b0;
    bidir_transmit = 1'b0;
    $display("bidir test done");
    spi_enable = 1'b0;
    tick(2);
    chk("select off", 16'h1, slave_select_line_o);
    spi_enable = 1'b1;
    soft_select_enable = 1'b1;
    tick(6);
    chk("soft high fault", 16'h0, config_fault_flag);
    chk("soft high role", 16'h1, master_active);
    soft_select_level = 1'b0;
    tick(6);
    chk("soft low fault", 16'h1, config_fault_flag);
    chk("soft low role", 16'h0, master_active);
    soft_select_level = 1'b1;
    tick(4);
    chk("fault kept", 16'h1, config_fault_flag);
    clear_fault();
    chk("fault cleared", 16'h0, config_fault_flag);
    $display("soft select fault test done");
    soft_select_enable = 1'b0;
    select_output_drive = 1'b0;
    pull = 1'b1;
    tick(6);
    chk("pin low fault", 16'h1, config_fault_flag);
    pull = 1'b0;
    tick(2);
    clear_fault();
    $display("pin input fault test done");
    master_select = 1'b0;
    pulse_write(16'h00a5);
    tick(4);
    u_peer.xfer(16'h003c, 1'b1, pr);
    tick(8);
    chk("slave tx", 16'h00a5, pr);
    chk("slave rx", 16'h003c, rx_data & 16'h00ff);
    chk("slave rx full", 16'h1, rx_buffer_full_flag);
    chk("slave tx empty", 16'h1, tx_buffer_empty_flag);
    pulse_read();
    soft_select_enable = 1'b1;
    u_peer.xfer(16'h0055, 1'b1, pr);
    tick(8);
    chk("soft deselect", 16'h0, rx_buffer_full_flag);
    soft_select_level = 1'b0;
    tick(2);
    u_peer.xfer(16'h0081, 1'b0, pr);
    tick(8);
    chk("soft select rx full", 16'h1, rx_buffer_full_flag);
    chk("soft select rx", 16'h0081, rx_data & 16'h00ff);
    $display("slave tests done");
    finish_test();
  end
endmodule : tb
